// File: pkg/psm_pkg.sv
// constants, types and helpers for the password serial memory slave
package psm_pkg;
  // ********************
  // array organisation
  // ********************
  localparam int ARRAY_BYTES = 496;
  localparam int SECTORS     = 62;
  localparam int PW_BITS     = 64;
  localparam int RTR_BITS    = 32;
  localparam int RETRY_LIMIT = 8;
  localparam int FIFO_DEPTH  = 16;
  localparam int FIFO_WIDTH  = 8;

  // ********************
  // command bytes
  // ********************
  localparam logic [7:0] CMD_POLL    = 8'h55;
  localparam logic [7:0] CMD_CHG_WPW = 8'hFC;
  localparam logic [7:0] CMD_CHG_RPW = 8'hFE;

  // ********************
  // timing
  // ********************
  localparam int CLK_HZ           = 20_000_000;
  localparam int NV_WRITE_TIME_US = 10_000;
  localparam int NV_WRITE_CYC     = NV_WRITE_TIME_US * (CLK_HZ / 1_000_000);

  // arbitrary value, not tied to any part
  localparam logic [31:0] RTR_PATTERN_DEF = 32'h5A3C_0F81;
  localparam logic [63:0] PW_RESET        = 64'h0000_0000_0000_0000;

  typedef enum logic [2:0] {
    ST_IDLE, ST_CMD, ST_PW, ST_WDATA, ST_RDATA, ST_RTR
  } psm_state_t;

  typedef enum logic [1:0] {OP_WRITE, OP_READ, OP_CHG_WPW, OP_CHG_RPW} psm_op_t;

  typedef struct packed {
    logic       en;
    logic [8:0] addr;
    logic [7:0] data;
  } psm_wr_t;

  function automatic logic [8:0] sect_base(input logic [5:0] s);
    return {s, 3'h0};
  endfunction : sect_base
endpackage : psm_pkg

// File: verilog/psm_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ns
module psm_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic         sys_clk_in,
  input  wire logic         rst_n_in,
  input  wire logic         flush_in,
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic      [W-1:0] out_data_out
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0]  wp_reg, wp_next, rp_reg, rp_next;
  logic         push, pop;

  assign in_ready_out  = (wp_reg - rp_reg) != (AW+1)'(D);
  assign out_valid_out = wp_reg != rp_reg;
  assign out_data_out  = mem[rp_reg[AW-1:0]];
  assign push          = in_valid_in && in_ready_out && !flush_in;
  assign pop           = out_valid_out && out_ready_in && !flush_in;

  always_comb begin
    wp_next = wp_reg;
    rp_next = rp_reg;
    if (flush_in) begin
      rp_next = wp_reg;
    end else begin
      if (push) wp_next = wp_reg + (AW+1)'(1);
      if (pop) rp_next = rp_reg + (AW+1)'(1);
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (push) mem[wp_reg[AW-1:0]] <= in_data_in;
  end
endmodule : psm_fifo

// File: verilog/psm_slave.sv
// password guarded serial memory slave: protocol, passwords, array
`timescale 1ns/1ns
module psm_slave #(
  parameter int          NV_CYC      = psm_pkg::NV_WRITE_CYC,
  parameter logic [31:0] RTR_PATTERN = psm_pkg::RTR_PATTERN_DEF
) (
  input  wire logic sys_clk_in,
  input  wire logic rst_n_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  input  wire logic card_rst_in,
  output logic      sda_out,
  output logic      sda_oe_out
);
  // ********************
  // pin synchronisers
  // ********************
  logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3, rp_s1, rp_s2, rp_s3;
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      {scl_s1, scl_s2, scl_s3} <= 3'h7;
      {sda_s1, sda_s2, sda_s3} <= 3'h7;
      {rp_s1, rp_s2, rp_s3}    <= 3'h0;
    end else begin
      {scl_s1, scl_s2, scl_s3} <= {scl_in, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_s3} <= {sda_in, sda_s1, sda_s2};
      {rp_s1, rp_s2, rp_s3}    <= {card_rst_in, rp_s1, rp_s2};
    end
  end

  logic scl_rise, scl_fall, start, stop, rst_rise;
  assign scl_rise = scl_s2 && !scl_s3;
  assign scl_fall = !scl_s2 && scl_s3;
  assign start    = scl_s2 && scl_s3 && sda_s3 && !sda_s2;
  assign stop     = scl_s2 && scl_s3 && !sda_s3 && sda_s2;
  assign rst_rise = rp_s2 && !rp_s3;

  // ********************
  // state
  // ********************
  psm_pkg::psm_state_t state_reg, state_next, after_reg, after_next;
  psm_pkg::psm_op_t    op_reg, op_next;
  psm_pkg::psm_wr_t    wr;
  logic [3:0]  bitcnt_reg, bitcnt_next, bytecnt_reg, bytecnt_next;
  logic [3:0]  txcnt_reg, txcnt_next, retry_reg, retry_next;
  logic [7:0]  sh_reg, sh_next, tx_reg, tx_next, b;
  logic [5:0]  sect_reg, sect_next;
  logic [4:0]  rtr_reg, rtr_next;
  logic [63:0] pw_reg, pw_next, rpw_reg, rpw_next, wpw_reg, wpw_next, wbuf_reg, wbuf_next;
  logic [31:0] busy_reg, busy_next;
  logic [8:0]  cidx_reg, cidx_next, rd_reg, rd_next;
  logic        ack_drv_reg, ack_drv_next, ack_val_reg, ack_val_next, grant_reg, grant_next;
  logic        wipe_reg, wipe_next, commit_reg, commit_next, rd_act_reg, rd_act_next;
  logic        oe_reg, oe_next, busy, rtr_go, pop, in_rdy, out_vld;
  logic [7:0]  out_data;
  logic [63:0] pw_full;
  logic [7:0]  mem [psm_pkg::ARRAY_BYTES];

  assign busy    = (busy_reg != 32'h0) || wipe_reg || commit_reg;
  assign rtr_go  = rst_rise && !busy;
  assign b       = {sh_reg[6:0], sda_s2};
  assign pw_full = {pw_reg[55:0], b};

  psm_fifo #(.W(psm_pkg::FIFO_WIDTH), .D(psm_pkg::FIFO_DEPTH)) u_fifo (
    .sys_clk_in    (sys_clk_in),
    .rst_n_in      (rst_n_in),
    .flush_in      (!rd_act_reg),
    .in_valid_in   (rd_act_reg),
    .in_ready_out  (in_rdy),
    .in_data_in    (mem[rd_reg]),
    .out_valid_out (out_vld),
    .out_ready_in  (pop),
    .out_data_out  (out_data)
  );

  always_comb begin
    state_next = state_reg; after_next = after_reg; op_next = op_reg;
    bitcnt_next = bitcnt_reg; bytecnt_next = bytecnt_reg; txcnt_next = txcnt_reg;
    retry_next = retry_reg; sh_next = sh_reg; tx_next = tx_reg; sect_next = sect_reg;
    rtr_next = rtr_reg; pw_next = pw_reg; rpw_next = rpw_reg; wpw_next = wpw_reg;
    wbuf_next = wbuf_reg; busy_next = busy_reg; cidx_next = cidx_reg; rd_next = rd_reg;
    ack_drv_next = ack_drv_reg; ack_val_next = ack_val_reg; grant_next = grant_reg;
    wipe_next = wipe_reg; commit_next = commit_reg; rd_act_next = rd_act_reg;
    oe_next = oe_reg; pop = 1'b0; wr = '0;
    // background nonvolatile work, one byte per cycle; a password change is stored whole in one cycle
    if (wipe_reg) begin
      wr = '{1'b1, cidx_reg, 8'h00};
      rpw_next = psm_pkg::PW_RESET;
      wpw_next = psm_pkg::PW_RESET;
      if (cidx_reg == 9'(psm_pkg::ARRAY_BYTES - 1)) wipe_next = 1'b0;
      else cidx_next = cidx_reg + 9'h001;
    end else if (commit_reg) begin
      unique case (op_reg)
        psm_pkg::OP_CHG_WPW: begin
          wpw_next = wbuf_reg; commit_next = 1'b0;
        end
        psm_pkg::OP_CHG_RPW: begin
          rpw_next = wbuf_reg; commit_next = 1'b0;
        end
        psm_pkg::OP_WRITE, psm_pkg::OP_READ: begin
          wr = '{1'b1, psm_pkg::sect_base(sect_reg) | cidx_reg, wbuf_reg[63:56]};
          wbuf_next = {wbuf_reg[55:0], 8'h00};
          if (cidx_reg[2:0] == 3'h7) commit_next = 1'b0;
          cidx_next = cidx_reg + 9'h001;
        end
      endcase
    end
    if (busy_reg != 32'h0) busy_next = busy_reg - 32'h1;
    // prefetch, wrapping past the last sector
    if (rd_act_reg && in_rdy)
      rd_next = (rd_reg == 9'(psm_pkg::ARRAY_BYTES - 1)) ? 9'h000 : rd_reg + 9'h001;
    if (rtr_go) begin
      state_next = psm_pkg::ST_RTR; rtr_next = 5'h00; oe_next = !RTR_PATTERN[0];
      grant_next = 1'b0; rd_act_next = 1'b0; ack_drv_next = 1'b0;
    end else begin
      unique case (state_reg)
        psm_pkg::ST_IDLE: if (start) begin
          state_next = psm_pkg::ST_CMD; bitcnt_next = 4'h0;
        end
        psm_pkg::ST_RTR: if (scl_fall) begin
          if (rtr_reg == 5'h1F) begin
            state_next = psm_pkg::ST_IDLE; oe_next = 1'b0;
          end else begin
            rtr_next = rtr_reg + 5'h01; oe_next = !RTR_PATTERN[rtr_reg + 5'h01];
          end
        end
        // start and stop are not watched while the master reads
        psm_pkg::ST_RDATA: begin
          if (scl_fall) begin
            if (txcnt_reg == 4'h0) begin
              tx_next = out_data; pop = 1'b1; oe_next = !out_data[7]; txcnt_next = 4'h1;
            end else if (txcnt_reg < 4'h8) begin
              tx_next = {tx_reg[6:0], 1'b0}; oe_next = !tx_reg[6];
              txcnt_next = txcnt_reg + 4'h1;
            end else if (txcnt_reg == 4'h8) begin
              oe_next = 1'b0; txcnt_next = 4'h9;
            end
          end else if (scl_rise && txcnt_reg == 4'h9) begin
            if (sda_s2) begin
              state_next = psm_pkg::ST_IDLE; rd_act_next = 1'b0; grant_next = 1'b0;
            end else begin
              txcnt_next = 4'h0;
            end
          end
        end
        psm_pkg::ST_CMD, psm_pkg::ST_PW, psm_pkg::ST_WDATA: begin
          if (start) begin
            state_next = psm_pkg::ST_CMD; bitcnt_next = 4'h0;
            ack_drv_next = 1'b0; oe_next = 1'b0;
          end else if (stop) begin
            if (state_reg == psm_pkg::ST_WDATA && bytecnt_reg == 4'h8) begin
              commit_next = 1'b1; cidx_next = 9'h000; busy_next = 32'(NV_CYC);
            end
            state_next = psm_pkg::ST_IDLE; ack_drv_next = 1'b0; oe_next = 1'b0;
            if (state_reg == psm_pkg::ST_WDATA) grant_next = 1'b0;
          end else if (scl_rise && bitcnt_reg < 4'h8) begin
            sh_next = b; bitcnt_next = bitcnt_reg + 4'h1;
            if (bitcnt_reg == 4'h7) begin
              ack_val_next = 1'b1; after_next = state_reg;
              unique case (state_reg)
                psm_pkg::ST_CMD: begin
                  after_next = psm_pkg::ST_PW; bytecnt_next = 4'h0; grant_next = 1'b0;
                  if (busy) begin
                    ack_val_next = 1'b0; after_next = psm_pkg::ST_IDLE;
                  end else if (b == psm_pkg::CMD_POLL) begin
                    ack_val_next = grant_reg;
                    grant_next = grant_reg;
                    bytecnt_next = 4'h0; wbuf_next = 64'h0;
                    if (!grant_reg) after_next = psm_pkg::ST_IDLE;
                    else if (op_reg == psm_pkg::OP_READ) begin
                      after_next = psm_pkg::ST_RDATA; rd_act_next = 1'b1;
                      rd_next = psm_pkg::sect_base(sect_reg); txcnt_next = 4'h0;
                    end else after_next = psm_pkg::ST_WDATA;
                  end else if (b == psm_pkg::CMD_CHG_WPW) op_next = psm_pkg::OP_CHG_WPW;
                  else if (b == psm_pkg::CMD_CHG_RPW) op_next = psm_pkg::OP_CHG_RPW;
                  else if (b[7] && b[6:1] < 6'(psm_pkg::SECTORS)) begin
                    op_next = b[0] ? psm_pkg::OP_READ : psm_pkg::OP_WRITE; sect_next = b[6:1];
                  end else begin
                    ack_val_next = 1'b0; after_next = psm_pkg::ST_IDLE;
                  end
                end
                psm_pkg::ST_PW: begin
                  pw_next = pw_full; bytecnt_next = bytecnt_reg + 4'h1;
                  if (bytecnt_reg == 4'h7) begin
                    after_next = psm_pkg::ST_IDLE; busy_next = 32'(NV_CYC);
                    if (pw_full == ((op_reg == psm_pkg::OP_READ) ? rpw_reg : wpw_reg)) begin
                      grant_next = 1'b1; retry_next = 4'h0;
                    end else if (retry_reg == 4'(psm_pkg::RETRY_LIMIT - 1)) begin
                      retry_next = 4'h0; wipe_next = 1'b1; cidx_next = 9'h000;
                    end else retry_next = retry_reg + 4'h1;
                  end
                end
                psm_pkg::ST_WDATA: begin
                  if (bytecnt_reg < 4'h8) wbuf_next = {wbuf_reg[55:0], b};
                  if (bytecnt_reg < 4'h9) bytecnt_next = bytecnt_reg + 4'h1;
                end
                default: ;
              endcase
            end
          end else if (scl_fall && bitcnt_reg == 4'h8) begin
            if (!ack_drv_reg) begin
              ack_drv_next = 1'b1; oe_next = ack_val_reg;
            end else begin
              ack_drv_next = 1'b0; oe_next = 1'b0; bitcnt_next = 4'h0;
              state_next = after_reg;
              if (after_reg == psm_pkg::ST_RDATA) begin
                tx_next = out_data; pop = 1'b1; oe_next = !out_data[7]; txcnt_next = 4'h1;
              end
            end
          end
        end
        default: state_next = psm_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= psm_pkg::ST_IDLE; after_reg <= psm_pkg::ST_IDLE;
      op_reg <= psm_pkg::OP_WRITE; bitcnt_reg <= 4'h0; bytecnt_reg <= 4'h0;
      txcnt_reg <= 4'h0; retry_reg <= 4'h0; sh_reg <= 8'h00; tx_reg <= 8'h00;
      sect_reg <= 6'h00; rtr_reg <= 5'h00; pw_reg <= 64'h0;
      rpw_reg <= psm_pkg::PW_RESET; wpw_reg <= psm_pkg::PW_RESET;
      wbuf_reg <= 64'h0; busy_reg <= 32'h0; cidx_reg <= 9'h000; rd_reg <= 9'h000;
      ack_drv_reg <= 1'b0; ack_val_reg <= 1'b0; grant_reg <= 1'b0; wipe_reg <= 1'b0;
      commit_reg <= 1'b0; rd_act_reg <= 1'b0; oe_reg <= 1'b0; sda_out <= 1'b0;
    end else begin
      state_reg <= state_next; after_reg <= after_next; op_reg <= op_next;
      bitcnt_reg <= bitcnt_next; bytecnt_reg <= bytecnt_next; txcnt_reg <= txcnt_next;
      retry_reg <= retry_next; sh_reg <= sh_next; tx_reg <= tx_next; sect_reg <= sect_next;
      rtr_reg <= rtr_next; pw_reg <= pw_next; rpw_reg <= rpw_next; wpw_reg <= wpw_next;
      wbuf_reg <= wbuf_next; busy_reg <= busy_next; cidx_reg <= cidx_next; rd_reg <= rd_next;
      ack_drv_reg <= ack_drv_next; ack_val_reg <= ack_val_next; grant_reg <= grant_next;
      wipe_reg <= wipe_next; commit_reg <= commit_next; rd_act_reg <= rd_act_next;
      oe_reg <= oe_next; sda_out <= 1'b0;
    end
  end
  assign sda_oe_out = oe_reg;

  // array cells keep no reset: they model nonvolatile contents
  always_ff @(posedge sys_clk_in) begin
    if (wr.en) mem[wr.addr] <= wr.data;
  end

  // ********************
  // checks
  // ********************
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  idle_released_a: assert property (state_reg == psm_pkg::ST_IDLE |-> !oe_reg)
    else $error("data line driven in standby");
  busy_nack_a: assert property (state_reg == psm_pkg::ST_CMD && scl_rise && !start && !stop
    && !rtr_go && bitcnt_reg == 4'h7 && busy |=> !ack_val_reg)
    else $error("command acknowledged while busy");
  no_rtr_busy_a: assert property (busy && state_reg != psm_pkg::ST_RTR
    |=> state_reg != psm_pkg::ST_RTR)
    else $error("reset response during write cycle");
  wipe_pw_zero_a: assert property ($rose(wipe_reg) |=> rpw_reg == 64'h0 && wpw_reg == 64'h0)
    else $error("passwords not cleared by wipe");
  grant_retry_a: assert property ($rose(grant_reg) |-> retry_reg == 4'h0)
    else $error("retry count left after grant");
  read_aligned_a: assert property ($rose(rd_act_reg) |-> rd_reg[2:0] == 3'h0)
    else $error("read not sector aligned");
  start_abort_a: assert property (start && !rtr_go && state_reg inside {psm_pkg::ST_CMD,
    psm_pkg::ST_PW, psm_pkg::ST_WDATA} |=> state_reg == psm_pkg::ST_CMD && bitcnt_reg == 4'h0)
    else $error("start did not restart command input");
  stop_idle_a: assert property (stop && !rtr_go && state_reg inside {psm_pkg::ST_CMD,
    psm_pkg::ST_PW} |=> state_reg == psm_pkg::ST_IDLE && !commit_reg)
    else $error("stop during input did not reset");
  commit_eight_a: assert property ($rose(commit_reg) |-> $past(bytecnt_reg) == 4'h8)
    else $error("commit without eight bytes");
  tx_hold_a: assert property (state_reg == psm_pkg::ST_RDATA && (start || stop) && !rtr_go
    |=> state_reg == psm_pkg::ST_RDATA)
    else $error("start or stop honoured while sending");

  read_cov_c:   cover property (state_reg == psm_pkg::ST_RDATA && pop);
  commit_cov_c: cover property ($rose(commit_reg));
  wipe_cov_c:   cover property ($rose(wipe_reg));
  rtr_cov_c:    cover property (state_reg == psm_pkg::ST_RTR && rtr_reg == 5'h1F && scl_fall);
endmodule : psm_slave

// File: test/psm_master.sv
// two-wire bus master model facing the serial memory slave
`timescale 1ns/1ns
module psm_master (
  input  wire logic sys_clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_pull_out,
  output logic      card_rst_out
);
  // ********************
  // bus conditions
  // ********************
  initial begin
    scl_out      = 1'b1;
    sda_pull_out = 1'b0;
    card_rst_out = 1'b0;
  end
  task automatic start_c();
    @(negedge sys_clk_in);
    sda_pull_out = 1'b0;
    #250;
    scl_out = 1'b1;
    #200;
    sda_pull_out = 1'b1;
    #200;
    scl_out = 1'b0;
    #50;
  endtask : start_c
  task automatic stop_c();
    sda_pull_out = 1'b1;
    #200;
    scl_out = 1'b1;
    #200;
    sda_pull_out = 1'b0;
    #200;
  endtask : stop_c
  // ********************
  // bit and byte transfer
  // ********************
  // data set well before the rise so a late ack release never looks like a stop
  task automatic bit_x(input logic b, output logic r);
    sda_pull_out = !b;
    #200;
    scl_out = 1'b1;
    #50;
    r = sda_in;
    #100;
    scl_out = 1'b0;
    #50;
  endtask : bit_x
  task automatic byte_x(input logic [7:0] d, input logic ack_in, output logic [7:0] r,
                        output logic ack);
    for (int i = 7; i >= 0; i--) bit_x(d[i], r[i]);
    bit_x(ack_in, ack);
  endtask : byte_x
  // ack low at the rise, then released while the clock is still high: a stop on the wire
  task automatic ack_stop();
    sda_pull_out = 1'b1;
    #150;
    scl_out = 1'b1;
    #100;
    sda_pull_out = 1'b0;
    #100;
    scl_out = 1'b0;
    #50;
  endtask : ack_stop
  // ********************
  // reset response
  // ********************
  // clock parked low first: a fall after the pin rise would skip bit 0
  task automatic rtr(output logic [31:0] v);
    @(negedge sys_clk_in);
    scl_out = 1'b0;
    #200;
    card_rst_out = 1'b1;
    #400;
    card_rst_out = 1'b0;
    #200;
    for (int i = 0; i < 32; i++) begin
      scl_out = 1'b1;
      #100;
      v[i] = sda_in;
      #100;
      scl_out = 1'b0;
      #200;
    end
    scl_out = 1'b1;
    #200;
  endtask : rtr
endmodule : psm_master

// File: test/test_psm_slave.sv
// self-checking bench for the password serial memory slave
`timescale 1ns/1ns
module test_psm_slave;
  localparam int          NV    = 600;
  localparam int          LIMIT = 90000;
  localparam logic [63:0] DA    = 64'h1122_3344_5566_7788;
  localparam logic [63:0] DB    = 64'hA5C3_0F96_E17B_2D48;
  localparam logic [63:0] NEWW  = 64'h0F1E_2D3C_4B5A_6978;
  localparam logic [63:0] NEWR  = 64'hC3B4_A596_8778_6950;
  logic sys_clk;
  logic rst_n;
  logic scl;
  logic pull;
  logic card_rst;
  logic sda_oe;
  logic sda_o;
  logic sda_line;
  int   miscompares;
  int   n_tests;
  int   cycles = 0;
  // ********************
  // wiring
  // ********************
  // open drain: the line shows the driven level only while enabled, else the pull-up
  assign sda_line = !pull && !(sda_oe && !sda_o);
  psm_slave #(.NV_CYC(NV), .RTR_PATTERN(psm_pkg::RTR_PATTERN_DEF)) dut (
    .sys_clk_in(sys_clk), .rst_n_in(rst_n), .scl_in(scl), .sda_in(sda_line),
    .card_rst_in(card_rst), .sda_out(sda_o), .sda_oe_out(sda_oe));
  psm_master m (.sys_clk_in(sys_clk), .sda_in(sda_line), .scl_out(scl),
    .sda_pull_out(pull), .card_rst_out(card_rst));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = !sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      miscompares++;
      complete_run();
    end
  end
  // ********************
  // checks and helpers
  // ********************
  task automatic complete_run();
    $display("comparisons %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  task automatic chk1(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk1
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk32
  task automatic wait_nv();
    repeat (NV + 40) @(negedge sys_clk);
  endtask : wait_nv
  // command, password, wait out the busy time, then poll; frame left open on ack
  task automatic access(input logic [7:0] cmd, input logic [63:0] pw, input logic ok);
    logic [7:0] r;
    logic       a;
    m.start_c();
    m.byte_x(cmd, 1'b1, r, a);
    chk1(a, 1'b0);
    for (int i = 7; i >= 0; i--) begin
      m.byte_x(pw[i*8 +: 8], 1'b1, r, a);
      chk1(a, 1'b0);
    end
    m.stop_c();
    wait_nv();
    m.start_c();
    m.byte_x(psm_pkg::CMD_POLL, 1'b1, r, a);
    chk1(a, !ok);
    if (!ok) m.stop_c();
  endtask : access
  task automatic write_data(input logic [63:0] d, input int n);
    logic [7:0] r;
    logic       a;
    for (int k = 0; k < n; k++) begin
      m.byte_x(d[(7-k)*8 +: 8], 1'b1, r, a);
      chk1(a, 1'b0);
    end
    m.stop_c();
  endtask : write_data
  task automatic read_chk(input logic [127:0] exp, input int n);
    logic [7:0] r;
    logic       a;
    for (int k = 0; k < n; k++) begin
      m.byte_x(8'hFF, k == n - 1, r, a);
      chk8(r, exp[(15-k)*8 +: 8]);
    end
    m.stop_c();
  endtask : read_chk
  // ********************
  // scenarios
  // ********************
  task automatic t_rtr();
    logic [31:0] v;
    m.rtr(v);
    chk32(v, psm_pkg::RTR_PATTERN_DEF);
  endtask : t_rtr
  // eight wrong tries wipe the array: unknown cells read back as zero
  task automatic t_wipe();
    for (int i = 0; i < 8; i++) access(8'h81, 64'h0123_4567_89AB_CDEF, 1'b0);
    repeat (600) @(negedge sys_clk);
    access(8'h81, 64'h0, 1'b1);
    read_chk(128'h0, 16);
  endtask : t_wipe
  task automatic t_illegal();
    logic [7:0] r;
    logic       a;
    m.start_c();
    m.byte_x(8'hFD, 1'b1, r, a);
    chk1(a, 1'b1);
    m.stop_c();
    m.start_c();
    m.byte_x(psm_pkg::CMD_POLL, 1'b1, r, a);
    chk1(a, 1'b1);
    m.stop_c();
  endtask : t_illegal
  // last sector, short write left out, read wraps into wiped sector 0
  task automatic t_write_read();
    logic a;
    access(8'hFA, 64'h0, 1'b1);
    write_data(DA, 8);
    wait_nv();
    access(8'hFA, 64'h0, 1'b1);
    write_data(DB, 7);
    // half a command cut by a start, then half a command cut by a stop
    m.start_c();
    for (int i = 0; i < 4; i++) m.bit_x(1'b1, a);
    m.start_c();
    for (int i = 0; i < 4; i++) m.bit_x(1'b0, a);
    m.stop_c();
    access(8'hFB, 64'h0, 1'b1);
    read_chk({DA, 64'h0}, 16);
  endtask : t_write_read
  // stop pulse inside the master's ack while the slave sends: must not end the read
  task automatic t_read_hold();
    logic [7:0] r;
    logic       a;
    access(8'hFB, NEWR, 1'b1);
    for (int i = 7; i >= 0; i--) m.bit_x(1'b1, r[i]);
    m.ack_stop();
    chk8(r, DA[63:56]);
    m.byte_x(8'hFF, 1'b1, r, a);
    chk8(r, DA[55:48]);
    m.stop_c();
  endtask : t_read_hold
  task automatic t_busy();
    logic [7:0]  r;
    logic        a;
    logic [31:0] v;
    m.start_c();
    m.byte_x(8'h81, 1'b1, r, a);
    for (int i = 0; i < 8; i++) m.byte_x(8'h00, 1'b1, r, a);
    m.start_c();
    m.byte_x(8'h81, 1'b1, r, a);
    chk1(a, 1'b1);
    m.stop_c();
    m.rtr(v);
    chk32(v, 32'hFFFF_FFFF);
    wait_nv();
  endtask : t_busy
  task automatic t_chg_pw();
    access(psm_pkg::CMD_CHG_WPW, 64'h0, 1'b1);
    write_data(NEWW, 8);
    wait_nv();
    access(8'h80, 64'h0, 1'b0);
    access(8'h80, NEWW, 1'b1);
    m.stop_c();
    access(psm_pkg::CMD_CHG_RPW, NEWW, 1'b1);
    write_data(NEWR, 8);
    wait_nv();
    access(8'h81, 64'h0, 1'b0);
    access(8'h81, NEWR, 1'b1);
    read_chk(128'h0, 1);
  endtask : t_chg_pw
  initial begin
    rst_n       = 1'b0;
    miscompares = 0;
    n_tests     = 0;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    t_rtr();
    t_wipe();
    t_illegal();
    t_write_read();
    t_busy();
    t_chg_pw();
    t_read_hold();
    complete_run();
  end
endmodule : test_psm_slave
